// File: hdl/lpmc_defs.vh
// Constants for the low power mode controller: mode codes, regulator codes, timing.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef LPMC_DEFS_VH
`define LPMC_DEFS_VH

// Power states
`define LPMC_ST_RUN 3'h0
`define LPMC_ST_SLEEP 3'h1
`define LPMC_ST_STOP 3'h2
`define LPMC_ST_STANDBY 3'h3
`define LPMC_ST_POR 3'h4

// Low-power request codes from the core
`define LPMC_REQ_SLEEP 2'h1
`define LPMC_REQ_STOP 2'h2
`define LPMC_REQ_STANDBY 2'h3

// Regulator setting codes
`define LPMC_REG_NORMAL 2'h0
`define LPMC_REG_OVER 2'h1
`define LPMC_REG_UNDER 2'h2
`define LPMC_REG_PDOWN 2'h3

// Source counts
`define LPMC_EXT_LINES 16
`define LPMC_WAKE_PINS 6

// Power-on sequence length in ns and derived cycles at 10 ns
`define LPMC_POR_NS 1000
`define LPMC_CLK_NS 10
`define LPMC_POR_CYC ((`LPMC_POR_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)

`endif

// File: hdl/lpmc_sync.v
// Three-stage synchroniser bank with agreement of the last two stages.
// Assumes inputs asynchronous to ref_clk_in; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_b_in,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // Stage one feeds only stage two; output moves when two and three agree
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
  end
endmodule
`default_nettype wire

// File: hdl/lpmc_top.v
// Low power mode controller: run, sleep, stop, standby sequencing and regulator choice.
// Assumes the core requests entry with a one-cycle strobe; wake sources are asynchronous pins.
//
// Summary of operation
// RQ1: Sleep halts only the core; any interrupt or event resumes it.
// RQ2: Stop gates all core-domain clocks, PLL and both oscillators; retains state.
// RQ3: Stop uses main or low-power regulator, each normal or under-drive.
// RQ4: Any external event line source wakes the device from stop.
// RQ5: Standby powers off the regulator, oscillators and PLL; core state is lost.
// RQ6: Reset pin, watchdog, wakeup pin edge or clock event ends standby.
// RQ7: Standby is refused while the regulator is bypassed.
// RQ8: Bypass strap high disables the regulator; outside holds it high.
// RQ9: Bypassed regulator never runs over-drive or under-drive.
// RQ10: Regulator setting limited per state as the allowed table says.
// RQ11: Every real-time clock event raises an interrupt and wakes any low state.
// RQ12: Bypassed, core-domain reset input resets the extra core logic; pin not general I/O.
// RQ13: Any standby exit runs the full power-on sequence before core restart.
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defs.vh"
module lpmc_top #(
  parameter EXT_LINES = `LPMC_EXT_LINES,
  parameter WAKE_PINS = `LPMC_WAKE_PINS,
  parameter POR_CYCLES = `LPMC_POR_CYC
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_b_in,
  // Core request
  input wire lp_req_in,
  input wire [1:0] lp_mode_in,
  input wire stop_use_lpr_in,
  input wire stop_underdrive_in,
  input wire run_overdrive_in,
  input wire core_irq_in,
  // Wake sources (asynchronous)
  input wire [EXT_LINES-1:0] external_event_lines_in,
  input wire supply_level_detector_in,
  input wire usb_wakeup_in,
  input wire low_power_timer_in,
  input wire [3:0] rtc_event_in,
  input wire external_reset_pin_b_in,
  input wire independent_watchdog_in,
  input wire [WAKE_PINS-1:0] wakeup_pin_in,
  input wire [WAKE_PINS-1:0] wakeup_pin_rise_in,
  // Straps (asynchronous)
  input wire bypass_strap_in,
  input wire core_domain_reset_input_b_in,
  // Status and control outputs
  output reg [2:0] power_state_out,
  output reg core_clk_en_out,
  output reg periph_clk_en_out,
  output reg osc_pll_en_out,
  output reg core_domain_power_out,
  output reg core_reset_b_out,
  output reg extra_core_reset_b_out,
  output reg regulator_en_out,
  output reg main_regulator_out,
  output reg low_power_regulator_out,
  output reg [1:0] regulator_mode_out,
  output reg rtc_irq_out,
  output reg req_refused_out,
  output reg debug_por_block_out,
  output reg pa_gpio_allowed_out
);
  localparam SRCW = EXT_LINES + 3 + 4 + 2 + WAKE_PINS + 1;
  localparam [15:0] POR_LOAD = POR_CYCLES;

  wire [SRCW-1:0] sync_w;
  wire [EXT_LINES-1:0] ext_s;
  wire pvd_s, usb_s, lpt_s, wd_s, strap_s, cdr_b_s, external_reset_pin_b_s;
  wire [3:0] rtc_s;
  wire [WAKE_PINS-1:0] wk_s;

  // Wake sources and straps, except the reset pin and the edge selects, pass the three-stage synchroniser
  lpmc_sync #(.WIDTH(SRCW)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in({external_event_lines_in, supply_level_detector_in, usb_wakeup_in,
               low_power_timer_in, rtc_event_in, independent_watchdog_in, bypass_strap_in,
               wakeup_pin_in, core_domain_reset_input_b_in}),
    .sync_out(sync_w)
  );
  assign {ext_s, pvd_s, usb_s, lpt_s, rtc_s, wd_s, strap_s, wk_s, cdr_b_s} = sync_w;

  // Reset pin goes through its own three-stage synchroniser so it never merges with events
  wire [0:0] external_reset_pin_w;
  lpmc_sync #(.WIDTH(1)) u_sync_external_reset_pin (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in(~external_reset_pin_b_in),
    .sync_out(external_reset_pin_w)
  );
  assign external_reset_pin_b_s = ~external_reset_pin_w[0];

  // Edge memory for wakeup pins and clock events
  reg [WAKE_PINS-1:0] wk_prev_q;
  reg [3:0] rtc_prev_q;
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wk_prev_q <= {WAKE_PINS{1'b0}};
      rtc_prev_q <= 4'h0;
    end else begin
      wk_prev_q <= wk_s;
      rtc_prev_q <= rtc_s;
    end
  end

  // Each pin picks its own polarity: rising when set, falling otherwise
  wire [WAKE_PINS-1:0] wk_edge = (wakeup_pin_rise_in & wk_s & ~wk_prev_q) |
                                 (~wakeup_pin_rise_in & ~wk_s & wk_prev_q);
  wire rtc_evt = |(rtc_s & ~rtc_prev_q); // RQ11
  wire stop_wake = (|ext_s) | pvd_s | usb_s | lpt_s | rtc_evt; // RQ4
  wire standby_wake = ~external_reset_pin_b_s | wd_s | (|wk_edge) | rtc_evt; // RQ6

  // Regulator setting legal for a state; bypass removes over and under drive
  function [1:0] lpmc_reg_limit;
    input [2:0] st;
    input [1:0] want;
    input byp;
    begin
      case (st)
        `LPMC_ST_RUN, `LPMC_ST_SLEEP:
          lpmc_reg_limit = (want == `LPMC_REG_OVER && !byp) ? `LPMC_REG_OVER : `LPMC_REG_NORMAL; // RQ10 RQ9
        `LPMC_ST_STOP:
          lpmc_reg_limit = (want == `LPMC_REG_UNDER && !byp) ? `LPMC_REG_UNDER : `LPMC_REG_NORMAL; // RQ3 RQ9
        `LPMC_ST_STANDBY:
          lpmc_reg_limit = `LPMC_REG_PDOWN; // RQ10
        default:
          lpmc_reg_limit = `LPMC_REG_NORMAL;
      endcase
    end
  endfunction

  reg [2:0] state_q, state_d;
  reg [15:0] por_cnt_q, por_cnt_d;
  reg refused_d;
  reg lpr_q, lpr_d;
  reg ud_q, ud_d;

  // Mode sequencer; the reset pin is checked last, so it beats a same-cycle request or wake
  always @* begin
    state_d = state_q;
    por_cnt_d = por_cnt_q;
    refused_d = 1'b0;
    lpr_d = lpr_q;
    ud_d = ud_q;
    case (state_q)
      `LPMC_ST_POR: begin
        if (por_cnt_q != 16'h0000) begin
          por_cnt_d = por_cnt_q - 16'h0001;
        end else begin
          state_d = `LPMC_ST_RUN; // RQ13
        end
      end
      `LPMC_ST_RUN: begin
        if (lp_req_in) begin
          case (lp_mode_in)
            `LPMC_REQ_SLEEP: state_d = `LPMC_ST_SLEEP;
            `LPMC_REQ_STOP: begin
              state_d = `LPMC_ST_STOP;
              lpr_d = stop_use_lpr_in; // RQ3
              ud_d = stop_underdrive_in;
            end
            `LPMC_REQ_STANDBY: begin
              if (strap_s) begin
                refused_d = 1'b1; // RQ7
              end else begin
                state_d = `LPMC_ST_STANDBY;
              end
            end
            default: refused_d = 1'b1;
          endcase
        end
      end
      `LPMC_ST_SLEEP: begin
        if (core_irq_in | stop_wake) begin
          state_d = `LPMC_ST_RUN; // RQ1
        end
      end
      `LPMC_ST_STOP: begin
        if (stop_wake) begin
          state_d = `LPMC_ST_RUN; // RQ4
        end
      end
      `LPMC_ST_STANDBY: begin
        if (standby_wake) begin
          state_d = `LPMC_ST_POR; // RQ6 RQ13
          por_cnt_d = POR_LOAD;
        end
      end
      default: begin
        state_d = `LPMC_ST_POR;
        por_cnt_d = POR_LOAD;
      end
    endcase
    // Reset pin always restarts the power-on sequence
    if (!external_reset_pin_b_s && state_q != `LPMC_ST_STANDBY) begin
      state_d = `LPMC_ST_POR;
      por_cnt_d = POR_LOAD;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state_q <= `LPMC_ST_POR;
      por_cnt_q <= POR_LOAD;
      lpr_q <= 1'b0;
      ud_q <= 1'b0;
    end else begin
      state_q <= state_d;
      por_cnt_q <= por_cnt_d;
      lpr_q <= lpr_d;
      ud_q <= ud_d;
    end
  end

  // Wanted regulator setting for the next state
  wire [1:0] want_reg = (state_d == `LPMC_ST_STOP) ? (ud_d ? `LPMC_REG_UNDER : `LPMC_REG_NORMAL) :
                        (run_overdrive_in ? `LPMC_REG_OVER : `LPMC_REG_NORMAL);
  wire in_stop = (state_d == `LPMC_ST_STOP);
  wire in_stby = (state_d == `LPMC_ST_STANDBY);
  wire in_por = (state_d == `LPMC_ST_POR);

  // Registered outputs follow the next state so they line up with power_state_out, except extra_core_reset_b_out, a cycle behind when unbypassed
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      power_state_out <= `LPMC_ST_POR;
      core_clk_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
      osc_pll_en_out <= 1'b1;
      core_domain_power_out <= 1'b1;
      core_reset_b_out <= 1'b0;
      extra_core_reset_b_out <= 1'b0;
      regulator_en_out <= 1'b0;
      main_regulator_out <= 1'b0;
      low_power_regulator_out <= 1'b0;
      regulator_mode_out <= `LPMC_REG_NORMAL;
      rtc_irq_out <= 1'b0;
      req_refused_out <= 1'b0;
      debug_por_block_out <= 1'b0;
      pa_gpio_allowed_out <= 1'b0;
    end else begin
      power_state_out <= state_d;
      core_clk_en_out <= (state_d == `LPMC_ST_RUN); // RQ1 RQ2
      periph_clk_en_out <= ~in_stop & ~in_stby & ~in_por; // RQ1 RQ2
      osc_pll_en_out <= ~in_stop & ~in_stby; // RQ2 RQ5
      core_domain_power_out <= ~in_stby; // RQ5
      core_reset_b_out <= ~in_por & ~in_stby; // RQ13
      // Bypassed, the core-domain reset input holds the extra logic in reset
      extra_core_reset_b_out <= strap_s ? cdr_b_s : core_reset_b_out; // RQ12
      regulator_en_out <= ~strap_s & ~in_stby; // RQ8 RQ5
      main_regulator_out <= ~strap_s & ~in_stby & ~(in_stop & lpr_d); // RQ3
      low_power_regulator_out <= ~strap_s & in_stop & lpr_d; // RQ3
      regulator_mode_out <= lpmc_reg_limit(state_d, want_reg, strap_s); // RQ9 RQ10
      rtc_irq_out <= rtc_evt; // RQ11
      req_refused_out <= refused_d; // RQ7
      debug_por_block_out <= strap_s & ~cdr_b_s; // RQ12
      pa_gpio_allowed_out <= ~strap_s; // RQ12
    end
  end
endmodule
`default_nettype wire

// File: verif/lpmc_monitor.sv
// Checker on the power mode controller ports.
// Assumes one clock domain; bound onto lpmc_top at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module lpmc_monitor #(
  parameter EXT_LINES = 16
) (
  // Clock, reset, requests, wake sources, strap
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic lp_req_in,
  input wire logic [1:0] lp_mode_in,
  input wire logic [EXT_LINES-1:0] external_event_lines_in,
  input wire logic [3:0] rtc_event_in,
  input wire logic bypass_strap_in,
  // Outputs watched
  input wire logic [2:0] power_state_out,
  input wire logic core_clk_en_out,
  input wire logic periph_clk_en_out,
  input wire logic osc_pll_en_out,
  input wire logic core_domain_power_out,
  input wire logic regulator_en_out,
  input wire logic main_regulator_out,
  input wire logic [1:0] regulator_mode_out,
  input wire logic rtc_irq_out,
  input wire logic req_refused_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // State against clocks and regulator
  AST_SLEEP_CLK: assert property (power_state_out == 3'h1 |-> !core_clk_en_out && periph_clk_en_out)
    else $error("sleep clocks wrong");
  AST_STOP_CLK: assert property (power_state_out == 3'h2 |-> !core_clk_en_out && !osc_pll_en_out)
    else $error("stop clocks running");
  AST_STOP_REG: assert property (power_state_out == 3'h2 |-> regulator_mode_out inside {2'h0, 2'h2})
    else $error("stop regulator mode wrong");
  AST_STBY_OFF: assert property (power_state_out == 3'h3 |-> !regulator_en_out && !core_domain_power_out)
    else $error("standby power still on");
  AST_OVER_MAIN: assert property (regulator_mode_out == 2'h1 |-> power_state_out <= 3'h1 && main_regulator_out)
    else $error("over-drive outside run or sleep");
  // Wake timing; synchroniser lag stays well under 8 cycles
  AST_STOP_WAKE: assert property ($rose(|external_event_lines_in) && power_state_out == 3'h2
    |-> ##[1:8] power_state_out == 3'h0) else $error("stop not left");
  AST_RTC_IRQ: assert property ($rose(|rtc_event_in) && power_state_out <= 3'h2
    |-> ##[1:8] rtc_irq_out) else $error("no clock event interrupt");
  AST_STBY_POR: assert property (power_state_out == 3'h3 ##1 power_state_out != 3'h3
    |-> power_state_out == 3'h4) else $error("standby exit skips power-on");
  AST_BYP_REFUSE: assert property (lp_req_in && lp_mode_in == 2'h3 && power_state_out == 3'h0 && bypass_strap_in
    && $past(bypass_strap_in, 5) |=> power_state_out != 3'h3 ##[0:1] req_refused_out)
    else $error("standby taken while bypassed");
  // Main scenarios reached
  cover property (power_state_out == 3'h1 ##1 power_state_out == 3'h0);
  cover property (power_state_out == 3'h3 ##1 power_state_out == 3'h4);
  cover property (req_refused_out);
endmodule
bind lpmc_top lpmc_monitor #(.EXT_LINES(EXT_LINES)) u_lpmc_monitor (
  .ref_clk_in, .rst_b_in, .lp_req_in, .lp_mode_in, .external_event_lines_in, .rtc_event_in,
  .bypass_strap_in, .power_state_out, .core_clk_en_out, .periph_clk_en_out, .osc_pll_en_out,
  .core_domain_power_out, .regulator_en_out, .main_regulator_out, .regulator_mode_out,
  .rtc_irq_out, .req_refused_out);
`default_nettype wire

// File: verif/lpmc_wake_model.sv
// Wake source model: raises one source bit for 8 cycles on command.
// Bits: 15:0 lines, 16 supply, 17 usb, 18 timer, 22:19 clock, 23 watchdog, 29:24 pins, 30 reset pin.
`timescale 1ns/1ps
`default_nettype none
module lpmc_wake_model (
  // Clock and command
  input wire logic ref_clk_in,
  input wire logic go_in,
  input wire logic [4:0] idx_in,
  input wire logic [3:0] lag_in,
  // Sources, idle low
  output logic [30:0] src_out
);
  initial src_out = '0;
  // Lag makes prompt or slow sources; 8 cycles outlast the synchronisers
  always @(posedge ref_clk_in) begin : pulse
    logic [4:0] k;
    if (go_in) begin
      k = idx_in;
      repeat (lag_in) @(posedge ref_clk_in);
      src_out[k] <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      src_out[k] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/lpmc_top_tb_top.sv
// Testbench: request table, then reset and corner cases.
// Assumes lpmc_top, lpmc_wake_model and the bound checker; 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top_tb_top;
  typedef struct {int m, low_power_regulator, ud, src, st, rm, back;} lpmc_row_t;
  logic ref_clk_in = 0, rst_b_in = 0, lp_req_in = 0, stop_use_lpr_in = 0, stop_underdrive_in = 0;
  logic run_overdrive_in = 0, core_irq_in = 0, bypass_strap_in = 0, core_domain_reset_input_b_in = 1;
  logic [1:0] lp_mode_in = 0;
  logic go = 0;
  logic [4:0] idx = 0;
  logic [3:0] lag = 0;
  logic [30:0] src;
  wire [2:0] power_state_out;
  wire [1:0] regulator_mode_out;
  wire core_clk_en_out, periph_clk_en_out, osc_pll_en_out, core_domain_power_out, core_reset_b_out;
  wire extra_core_reset_b_out, regulator_en_out, main_regulator_out, low_power_regulator_out;
  wire rtc_irq_out, req_refused_out, debug_por_block_out, pa_gpio_allowed_out;
  int error_cnt = 0, checks_done = 0;
  lpmc_row_t rows[11] = '{'{1,0,0,0,1,0,0}, '{1,0,0,20,1,0,0}, '{2,0,0,15,2,0,0}, '{2,1,1,16,2,2,0},
    '{2,0,1,17,2,2,0}, '{2,1,0,18,2,0,0}, '{2,0,0,19,2,0,0}, '{3,0,0,23,3,3,4},
    '{3,0,0,29,3,3,4}, '{3,0,0,22,3,3,4}, '{3,0,0,30,3,3,4}};
  // Short power-on count keeps the run brief
  lpmc_top #(.POR_CYCLES(3)) u_lpmc_top (
    .ref_clk_in, .rst_b_in, .lp_req_in, .lp_mode_in, .stop_use_lpr_in, .stop_underdrive_in,
    .run_overdrive_in, .core_irq_in, .external_event_lines_in(src[15:0]),
    .supply_level_detector_in(src[16]), .usb_wakeup_in(src[17]), .low_power_timer_in(src[18]),
    .rtc_event_in(src[22:19]), .external_reset_pin_b_in(~src[30]), .independent_watchdog_in(src[23]),
    .wakeup_pin_in(src[29:24]), .wakeup_pin_rise_in(6'h3f), .bypass_strap_in,
    .core_domain_reset_input_b_in, .power_state_out, .core_clk_en_out, .periph_clk_en_out,
    .osc_pll_en_out, .core_domain_power_out, .core_reset_b_out, .extra_core_reset_b_out,
    .regulator_en_out, .main_regulator_out, .low_power_regulator_out, .regulator_mode_out,
    .rtc_irq_out, .req_refused_out, .debug_por_block_out, .pa_gpio_allowed_out);
  lpmc_wake_model u_lpmc_wake_model (.ref_clk_in, .go_in(go), .idx_in(idx), .lag_in(lag), .src_out(src));
  always #5 ref_clk_in = ~ref_clk_in;
  task cmp(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // Bounded poll, so a stuck state shows as a mismatch
  task wait_st(input logic [2:0] s);
    int n;
    n = 0;
    #1;
    while (power_state_out !== s && n < 200) begin
      tick(1);
      n++;
    end
    cmp(power_state_out, s);
  endtask
  task req(input int m, input int l, input int u);
    @(posedge ref_clk_in);
    lp_mode_in <= m[1:0];
    stop_use_lpr_in <= l[0];
    stop_underdrive_in <= u[0];
    lp_req_in <= 1'b1;
    @(posedge ref_clk_in);
    lp_req_in <= 1'b0;
  endtask
  task wake(input int k, input int l);
    @(posedge ref_clk_in);
    idx <= k[4:0];
    lag <= l[3:0];
    go <= 1'b1;
    @(posedge ref_clk_in);
    go <= 1'b0;
  endtask
  // Refusal pulse stands one cycle, so every cycle is looked at
  task refused;
    logic s;
    s = 1'b0;
    repeat (4) begin
      #1;
      s = s | req_refused_out;
      @(posedge ref_clk_in);
    end
    cmp(s, 1'b1);
    cmp(power_state_out, 3'h0);
  endtask
  // A few hundred cycles are expected; 100 us is ample
  initial begin
    #100us;
    error_cnt++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    wait_st(3'h0);
    foreach (rows[i]) begin
      req(rows[i].m, rows[i].low_power_regulator, rows[i].ud);
      tick(1);
      cmp(power_state_out, rows[i].st);
      cmp(regulator_mode_out, rows[i].rm);
      cmp(low_power_regulator_out, rows[i].st == 3 ? 0 : rows[i].low_power_regulator);
      cmp({core_clk_en_out, osc_pll_en_out, core_domain_power_out}, {1'b0, rows[i].st == 1, rows[i].st != 3});
      cmp(main_regulator_out, rows[i].st == 1 || (rows[i].st == 2 && rows[i].low_power_regulator == 0));
      wake(rows[i].src, i % 2 * 5);
      wait_st(rows[i].back);
      wait_st(3'h0);
      tick(12);
    end
    // Core interrupt ends sleep; peripherals keep running meanwhile
    req(1, 0, 0);
    tick(1);
    cmp(periph_clk_en_out, 1'b1);
    @(posedge ref_clk_in);
    core_irq_in <= 1'b1;
    wait_st(3'h0);
    @(posedge ref_clk_in);
    core_irq_in <= 1'b0;
    req(0, 0, 0);
    refused();
    run_overdrive_in <= 1'b1;
    tick(4);
    cmp(regulator_mode_out, 2'h1);
    // Strap held high for the whole bypass stretch
    @(posedge ref_clk_in);
    bypass_strap_in <= 1'b1;
    core_domain_reset_input_b_in <= 1'b0;
    tick(8);
    cmp(regulator_en_out, 1'b0);
    cmp(regulator_mode_out, 2'h0);
    cmp({debug_por_block_out, pa_gpio_allowed_out, extra_core_reset_b_out}, 3'h4);
    @(posedge ref_clk_in);
    core_domain_reset_input_b_in <= 1'b1;
    req(3, 0, 0);
    refused();
    req(2, 0, 1);
    tick(1);
    cmp(regulator_mode_out, 2'h0);
    wake(3, 0);
    wait_st(3'h0);
    @(posedge ref_clk_in);
    bypass_strap_in <= 1'b0;
    run_overdrive_in <= 1'b0;
    // Mid-run reset returns to the power-on state
    tick(12);
    rst_b_in <= 1'b0;
    tick(4);
    cmp({power_state_out[1:0], core_reset_b_out}, 3'h0);
    @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    wait_st(3'h0);
    tick(1);
    cmp(core_reset_b_out, 1'b1);
    conclude;
  end
endmodule
`default_nettype wire
